//--- spm_pkg.sv
// Functional notes
// - Per-channel select picks that channel's status
// - Code 000 shows signal lost status
// - Code 001 shows level below threshold
// - Code 010 shows PRBS sync status
// - Code 011 shows bipolar violation strobe
// - Code 100 shows transmit overcurrent status
// - Overcurrent tristates both transmit outputs
// - Code 101 shows alarm indication status
// - Pin index equals channel index
// - Sync pulses reference DCOs when selected
// - Frame sync low one line cycle
// - Frame sync only in master mode, DIGITAL_CONTROLLED_OSCILLATOR active
// - Single-rail tristate pin floats transmit outputs
// - Receive CMI enable selects optical input, DPLL
// - Transmit CMI drives ring only
// - Dual-rail makes tristate pin negative data
`default_nettype none
package spm_pkg;
   // ***********************************************
   // Sizes and register map
   // ***********************************************
   localparam int NCH = 4;
   localparam int CH_BITS = 5;
   localparam int IRQ_W = NCH * CH_BITS;
   localparam logic [7:0] OFS_CHCFG_BASE = 8'h00;
   localparam logic [7:0] OFS_GCFG = 8'h10;
   localparam logic [7:0] OFS_LSTAT = 8'h14;
   localparam logic [7:0] OFS_ISTAT = 8'h18;
   localparam logic [7:0] OFS_IMASK = 8'h1C;
   localparam int GCFG_SSF_LSB = 0;
   localparam int GCFG_T1_BIT = 2;
   localparam logic [9:0] CHCFG_RST = 10'h000;
   localparam logic [2:0] GCFG_RST = 3'h0;
   localparam logic [IRQ_W-1:0] IMASK_RST = 20'h00000;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // ***********************************************
   // Encodings
   // ***********************************************
   typedef enum logic [2:0] {
      PS_LOS  = 3'h0,
      PS_ANALOG_LEVEL_LOW_INDICATION = 3'h1,
      PS_PRBS = 3'h2,
      PS_BPV  = 3'h3,
      PS_XLS  = 3'h4,
      PS_AIS  = 3'h5
   } spm_psel_t;
   localparam logic [1:0] SSF_SYNC_IN = 2'h1;
   localparam logic [1:0] SSF_MASTER_8K = 2'h2;
   localparam logic [1:0] XC_DUAL_RAIL = 2'h1;
   // ***********************************************
   // Timing
   // ***********************************************
   localparam int CLK_HZ = 10000000;
   localparam int FSC_E1_NS = 488;
   localparam int FSC_T1_NS = 648;
   localparam int FRAME_NS = 125000;
   localparam int FSC_E1_CYC = FSC_E1_NS * (CLK_HZ / 1000000) / 1000;
   localparam int FSC_T1_CYC = FSC_T1_NS * (CLK_HZ / 1000000) / 1000;
   localparam int FRAME_CYC = FRAME_NS * (CLK_HZ / 1000000) / 1000;
   // ***********************************************
   // Carriers
   // ***********************************************
   typedef struct packed {
      logic [1:0] coding;
      logic       tx_cmi;
      logic       rx_cmi;
      logic [2:0] thr;
      logic [2:0] psel;
   } spm_chcfg_t;
   typedef struct packed {
      logic alarm_indication_detect;
      logic transmit_overcurrent_indication;
      logic bipolar_violation_pulse;
      logic prbs;
      logic signal_lost_indication;
   } spm_chstat_t;
endpackage
`default_nettype wire

//--- spm_top.sv
// Added by the designer: the AXI4-Lite register port and the address map.
`timescale 1ns/1ps
`default_nettype none
module spm_top (
   input  wire logic                          aclk,
   input  wire logic                          aresetn,
   input  wire logic [7:0]                    s_axi_awaddr,
   input  wire logic                          s_axi_awvalid,
   output var  logic                          s_axi_awready,
   input  wire logic [31:0]                   s_axi_wdata,
   input  wire logic [3:0]                    s_axi_wstrb,
   input  wire logic                          s_axi_wvalid,
   output var  logic                          s_axi_wready,
   output var  logic [1:0]                    s_axi_bresp,
   output var  logic                          s_axi_bvalid,
   input  wire logic                          s_axi_bready,
   input  wire logic [7:0]                    s_axi_araddr,
   input  wire logic                          s_axi_arvalid,
   output var  logic                          s_axi_arready,
   output var  logic [31:0]                   s_axi_rdata,
   output var  logic [1:0]                    s_axi_rresp,
   output var  logic                          s_axi_rvalid,
   input  wire logic                          s_axi_rready,
   input  wire spm_pkg::spm_chstat_t [3:0]    line_status,
   input  wire logic [3:0][2:0]               receive_level,
   input  wire logic [3:0]                    transmit_optical_data,
   input  wire logic                          dco_active,
   input  wire logic                          sync_pin,
   input  wire logic [3:0]                    transmit_tristate_input,
   input  wire logic [3:0]                    transmit_positive_data,
   output var  logic [3:0]                    multifunction_status_pin,
   output var  logic                          frame_sync_output,
   output var  logic                          dco_reference_pulse,
   output var  logic [3:0]                    receive_cmi_enable,
   output var  logic [3:0]                    transmit_line_ring,
   output var  logic [3:0]                    transmit_line_ring_oe,
   output var  logic [3:0]                    transmit_line_tip,
   output var  logic [3:0]                    transmit_line_tip_oe,
   output var  logic                          irq
);
   import spm_pkg::*;

   // ***********************************************
   // Helpers
   // ***********************************************
   function automatic logic [31:0] wmerge(input logic [31:0] old,
                                          input logic [31:0] nw,
                                          input logic [3:0]  strb);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (strb[b]) begin
            r[b*8 +: 8] = nw[b*8 +: 8];
         end
      end
      return r;
   endfunction

   function automatic logic mux_status(input logic [2:0]  sel,
                                       input spm_chstat_t st,
                                       input logic        analog_level_low_indication);
      logic r;
      r = 1'b0;
      case (sel)
         PS_LOS:  r = st.signal_lost_indication;
         PS_ANALOG_LEVEL_LOW_INDICATION: r = analog_level_low_indication;
         PS_PRBS: r = st.prbs;
         PS_BPV:  r = st.bipolar_violation_pulse;
         PS_XLS:  r = st.transmit_overcurrent_indication;
         PS_AIS:  r = st.alarm_indication_detect;
         default: r = 1'b0;
      endcase
      return r;
   endfunction

   // ***********************************************
   // Registers
   // ***********************************************
   spm_chcfg_t [3:0]   chcfg;
   logic [2:0]         gcfg;
   logic [IRQ_W-1:0]   istat;
   logic [IRQ_W-1:0]   imask;
   logic [IRQ_W-1:0]   prev_level;
   logic [7:0]         aw_addr;
   logic               aw_held;
   logic [31:0]        w_data;
   logic [3:0]         w_strb;
   logic               w_held;

   wire [1:0]        ssf      = gcfg[GCFG_SSF_LSB +: 2];
   wire              t1_mode  = gcfg[GCFG_T1_BIT];
   wire              do_write = aw_held && w_held && !s_axi_bvalid;
   wire              wr_ch    = (aw_addr[7:4] == OFS_CHCFG_BASE[7:4]);
   wire              wr_gcfg  = (aw_addr[7:2] == OFS_GCFG[7:2]);
   wire              wr_istat = (aw_addr[7:2] == OFS_ISTAT[7:2]);
   wire              wr_imask = (aw_addr[7:2] == OFS_IMASK[7:2]);
   wire              wr_lstat = (aw_addr[7:2] == OFS_LSTAT[7:2]);
   wire              wr_ok    = wr_ch || wr_gcfg || wr_istat || wr_imask || wr_lstat;
   wire [31:0]       wr_word  = wmerge(32'h00000000, w_data, w_strb);
   wire [IRQ_W-1:0]  clr_mask = (do_write && wr_istat) ? wr_word[IRQ_W-1:0] : '0;
   wire [31:0]       ch_word  = wmerge({22'h000000, chcfg[aw_addr[3:2]]}, w_data, w_strb);
   wire [31:0]       msk_word = wmerge({12'h000, imask}, w_data, w_strb);

   // ***********************************************
   // Live status and event capture
   // ***********************************************
   logic [IRQ_W-1:0] live;
   logic [3:0]       analog_level_low_indication;
   logic [3:0]       ts_s1, ts_s2, ts_s3, ts_val;
   logic [3:0]       xp_s1, xp_s2, xp_s3, xp_val;

   genvar gi;
   generate
      for (gi = 0; gi < NCH; gi++) begin : g_ch
         assign analog_level_low_indication[gi] = receive_level[gi] < chcfg[gi].thr;
         assign live[gi*CH_BITS +: CH_BITS] = line_status[gi];
      end
   endgenerate

   wire [IRQ_W-1:0] rise = live & ~prev_level;

   // Set wins over a simultaneous clear
   wire [IRQ_W-1:0] next_istat = (istat & ~clr_mask) | rise;

   // ***********************************************
   // AXI4-Lite write side
   // ***********************************************
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= RESP_OKAY;
         aw_held       <= 1'b0;
         w_held        <= 1'b0;
         aw_addr       <= 8'h00;
         w_data        <= 32'h00000000;
         w_strb        <= 4'h0;
      end else begin
         s_axi_awready <= !aw_held && !s_axi_awready && s_axi_awvalid;
         s_axi_wready  <= !w_held && !s_axi_wready && s_axi_wvalid;
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end
         if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            aw_held      <= 1'b0;
            w_held       <= 1'b0;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         chcfg      <= {NCH{CHCFG_RST}};
         gcfg       <= GCFG_RST;
         imask      <= IMASK_RST;
         istat      <= '0;
         prev_level <= '0;
      end else begin
         prev_level <= live;
         istat      <= next_istat;
         if (do_write && wr_ch) begin
            chcfg[aw_addr[3:2]] <= ch_word[9:0];
         end
         if (do_write && wr_gcfg) begin
            gcfg <= wr_word[2:0];
         end
         if (do_write && wr_imask) begin
            imask <= msk_word[IRQ_W-1:0];
         end
      end
   end

   // ***********************************************
   // AXI4-Lite read side
   // ***********************************************
   logic [31:0] rd_word;
   logic        rd_ok;

   always_comb begin
      rd_word = 32'h00000000;
      rd_ok   = 1'b1;
      if (s_axi_araddr[7:4] == OFS_CHCFG_BASE[7:4]) begin
         rd_word[9:0] = chcfg[s_axi_araddr[3:2]];
      end else if (s_axi_araddr[7:2] == OFS_GCFG[7:2]) begin
         rd_word[2:0] = gcfg;
      end else if (s_axi_araddr[7:2] == OFS_LSTAT[7:2]) begin
         rd_word[IRQ_W-1:0] = live;
      end else if (s_axi_araddr[7:2] == OFS_ISTAT[7:2]) begin
         rd_word[IRQ_W-1:0] = istat;
      end else if (s_axi_araddr[7:2] == OFS_IMASK[7:2]) begin
         rd_word[IRQ_W-1:0] = imask;
      end else begin
         rd_ok = 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h00000000;
         s_axi_rresp   <= RESP_OKAY;
      end else begin
         s_axi_arready <= !s_axi_rvalid && !s_axi_arready && s_axi_arvalid;
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_word;
            s_axi_rresp  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // ***********************************************
   // Pin synchronisers
   // ***********************************************
   logic sy_s1, sy_s2, sy_s3, sy_val;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         {ts_s1, ts_s2, ts_s3, ts_val} <= '0;
         {xp_s1, xp_s2, xp_s3, xp_val} <= '0;
         {sy_s1, sy_s2, sy_s3, sy_val} <= '0;
      end else begin
         ts_s1 <= transmit_tristate_input;
         ts_s2 <= ts_s1;
         ts_s3 <= ts_s2;
         ts_val <= (ts_val & (ts_s2 ^ ts_s3)) | (ts_s2 & ~(ts_s2 ^ ts_s3));
         xp_s1 <= transmit_positive_data;
         xp_s2 <= xp_s1;
         xp_s3 <= xp_s2;
         xp_val <= (xp_val & (xp_s2 ^ xp_s3)) | (xp_s2 & ~(xp_s2 ^ xp_s3));
         sy_s1 <= sync_pin;
         sy_s2 <= sy_s1;
         sy_s3 <= sy_s2;
         if (sy_s2 == sy_s3) begin
            sy_val <= sy_s2;
         end
      end
   end

   // ***********************************************
   // Sync reference and frame sync
   // ***********************************************
   logic        sy_prev;
   logic [10:0] frame_cnt;

   wire         sync_rise  = sy_val && !sy_prev;
   wire         fsc_run    = (ssf == SSF_MASTER_8K) && dco_active;
   wire [10:0]  fsc_width  = t1_mode ? 11'(FSC_T1_CYC) : 11'(FSC_E1_CYC);
   wire         frame_wrap = (frame_cnt == 11'(FRAME_CYC - 1));

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sy_prev             <= 1'b0;
         dco_reference_pulse <= 1'b0;
         frame_cnt           <= 11'h000;
         frame_sync_output   <= 1'b1;
      end else begin
         sy_prev             <= sy_val;
         dco_reference_pulse <= sync_rise && (ssf == SSF_SYNC_IN);
         if (!fsc_run || frame_wrap) begin
            frame_cnt <= 11'h000;
         end else begin
            frame_cnt <= frame_cnt + 11'h001;
         end
         frame_sync_output <= !(fsc_run && (frame_cnt < fsc_width));
      end
   end

   // ***********************************************
   // Per-channel pins
   // ***********************************************
   logic [3:0] mfp_next, ring_next, ring_oe_next, tip_next, tip_oe_next;
   logic [3:0] rxcmi_next;

   generate
      for (gi = 0; gi < NCH; gi++) begin : g_pin
         wire dual   = (chcfg[gi].coding == XC_DUAL_RAIL);
         wire float  = line_status[gi].transmit_overcurrent_indication || (!dual && ts_val[gi]);
         wire neg    = dual ? ts_val[gi] : 1'b0;
         assign mfp_next[gi]     = mux_status(chcfg[gi].psel, line_status[gi],
                                              analog_level_low_indication[gi]);
         assign ring_next[gi]    = chcfg[gi].tx_cmi ? transmit_optical_data[gi]
                                                    : xp_val[gi];
         assign ring_oe_next[gi] = !float;
         assign tip_next[gi]     = chcfg[gi].tx_cmi ? 1'b0 : neg;
         assign tip_oe_next[gi]  = !float && !chcfg[gi].tx_cmi;
         assign rxcmi_next[gi]   = chcfg[gi].rx_cmi;
      end
   endgenerate

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         multifunction_status_pin <= 4'h0;
         transmit_line_ring       <= 4'h0;
         transmit_line_ring_oe    <= 4'h0;
         transmit_line_tip        <= 4'h0;
         transmit_line_tip_oe     <= 4'h0;
         receive_cmi_enable       <= 4'h0;
         irq                      <= 1'b0;
      end else begin
         multifunction_status_pin <= mfp_next;
         transmit_line_ring       <= ring_next;
         transmit_line_ring_oe    <= ring_oe_next;
         transmit_line_tip        <= tip_next;
         transmit_line_tip_oe     <= tip_oe_next;
         receive_cmi_enable       <= rxcmi_next;
         irq                      <= |(next_istat & imask);
      end
   end
endmodule
`default_nettype wire

//--- spm_chk.sv
`timescale 1ns/1ps
`default_nettype none
module spm_chk
   import spm_pkg::*;
(
   input wire logic                        aclk,
   input wire logic                        aresetn,
   input wire logic [7:0]                  s_axi_araddr,
   input wire logic                        s_axi_arvalid,
   input wire logic                        s_axi_arready,
   input wire logic [31:0]                 s_axi_rdata,
   input wire logic [1:0]                  s_axi_rresp,
   input wire logic                        s_axi_rvalid,
   input wire logic                        s_axi_rready,
   input wire spm_pkg::spm_chstat_t [3:0]  line_status,
   input wire logic [3:0][2:0]             receive_level,
   input wire logic                        dco_active,
   input wire logic [3:0]                  multifunction_status_pin,
   input wire logic                        frame_sync_output,
   input wire logic                        dco_reference_pulse,
   input wire logic [3:0]                  transmit_line_ring_oe,
   input wire logic [3:0]                  transmit_line_tip_oe
);
   // ***********************************************
   // Frame gap counter
   // ***********************************************
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   logic [11:0] gap;
   logic        gap_ok;
   always_ff @(posedge aclk) begin
      if (!aresetn || !dco_active) begin
         gap_ok <= 1'b0;
      end else if ($fell(frame_sync_output)) begin
         gap_ok <= 1'b1;
      end
      if ($fell(frame_sync_output)) begin
         gap <= 12'h000;
      end else if (gap != 12'hFFF) begin
         gap <= gap + 12'h001;
      end
   end
   // ***********************************************
   // Properties
   // ***********************************************
   a_fsc_width: assert property (
      $fell(frame_sync_output) |-> !frame_sync_output [*4] ##[1:3] frame_sync_output)
      else $error("Frame sync low time wrong");
   a_fsc_period: assert property (
      $fell(frame_sync_output) && gap_ok |-> gap == 12'(FRAME_CYC - 1))
      else $error("Frame sync period wrong");
   a_fsc_idle: assert property (
      !dco_active [*3] |=> frame_sync_output)
      else $error("Frame sync pulse without active oscillator");
   a_ref_pulse: assert property (
      dco_reference_pulse |=> !dco_reference_pulse)
      else $error("Reference pulse longer than one cycle");
   a_read_slverr: assert property (
      s_axi_arvalid && s_axi_arready && s_axi_araddr > OFS_IMASK |=>
         s_axi_rvalid && s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0)
      else $error("Unmapped read not refused");
   a_rvalid_hold: assert property (
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("Read data dropped before taken");
   a_ar_pulse: assert property (
      s_axi_arready |=> !s_axi_arready)
      else $error("Read address ready held");
   for (genvar i = 0; i < NCH; i++) begin : g_ch
      a_ovc_float: assert property (
         line_status[i].transmit_overcurrent_indication |=> !transmit_line_ring_oe[i] && !transmit_line_tip_oe[i])
         else $error("Overcurrent left line driven");
      a_pin_own_chan: assert property (
         multifunction_status_pin[i] |->
            $past(line_status[i]) != 5'h00 || $past(receive_level[i]) != 3'h7)
         else $error("Status pin without own channel cause");
   end
endmodule
`default_nettype wire

//--- spm_framer.sv
`timescale 1ns/1ps
`default_nettype none
module spm_framer (
   input  wire logic        aclk,
   input  wire logic        sync_req,
   input  wire logic [3:0]  tri_req,
   output var  logic        sync_pin,
   output var  logic [3:0]  transmit_tristate_input,
   output var  logic [3:0]  transmit_positive_data,
   output var  logic [3:0]  transmit_optical_data
);
   // ***********************************************
   // Far side pins
   // ***********************************************
   logic [3:0] cnt = 4'h0;
   logic [3:0] xp  = 4'h0;
   always_ff @(posedge aclk) begin
      if (sync_req) begin
         cnt <= 4'h6;
      end else if (cnt != 4'h0) begin
         cnt <= cnt - 4'h1;
      end
      xp <= ~xp;
   end
   assign transmit_positive_data = xp;
   assign sync_pin = cnt != 4'h0;
   assign transmit_tristate_input = tri_req;
   assign transmit_optical_data = 4'h9;
endmodule
`default_nettype wire

//--- status_port_mux_line_select_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module status_port_mux_line_select_tb_top;
   import spm_pkg::*;
   // ***********************************************
   // Bench signals
   // ***********************************************
   logic aclk = 1'b0, aresetn = 1'b0, dco_active = 1'b0, sync_req = 1'b0;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rv;
   logic [3:0] s_axi_wstrb = 4'hF, tri_req = 4'h0;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   spm_chstat_t [3:0] line_status = '0;
   logic [3:0][2:0] receive_level = '1;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp, resp;
   logic sync_pin, frame_sync_output, dco_reference_pulse, irq;
   logic [3:0] transmit_tristate_input, transmit_positive_data, transmit_optical_data;
   logic [3:0] multifunction_status_pin, receive_cmi_enable, transmit_line_ring;
   logic [3:0] transmit_line_ring_oe, transmit_line_tip_oe, transmit_line_tip;
   int failures = 0, cmp_count = 0, cyc = 0;
   logic [4:0] sel_bit [8] = '{5'h01, 5'h00, 5'h02, 5'h04, 5'h08, 5'h10, 5'h00, 5'h00};
   int fx [4][3] = '{'{2, 1, 4}, '{6, 1, 6}, '{0, 1, 0}, '{2, 0, 0}};
   spm_top DUT (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
      .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
      .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .line_status,
      .receive_level, .transmit_optical_data, .dco_active, .sync_pin,
      .transmit_tristate_input, .transmit_positive_data, .multifunction_status_pin,
      .frame_sync_output, .dco_reference_pulse, .receive_cmi_enable, .transmit_line_ring,
      .transmit_line_ring_oe, .transmit_line_tip, .transmit_line_tip_oe, .irq);
   spm_framer u_far (.aclk, .sync_req, .tri_req, .sync_pin, .transmit_tristate_input,
      .transmit_positive_data, .transmit_optical_data);
   always #50 aclk = ~aclk;
   always @(posedge aclk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         failures++;
         complete_run();
      end
   end
   // ***********************************************
   // Tasks
   // ***********************************************
   task automatic complete_run();
      if (failures == 0 && cmp_count > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         failures++;
         $display("[ERR] %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
      resp = s_axi_bresp;
   endtask
   task automatic rd(input logic [7:0] a);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      do @(posedge aclk); while (!s_axi_arready);
      s_axi_arvalid <= 1'b0;
      do @(posedge aclk); while (!s_axi_rvalid);
      s_axi_rready <= 1'b1;
      @(posedge aclk);
      s_axi_rready <= 1'b0;
      rv = s_axi_rdata;
      resp = s_axi_rresp;
   endtask
   // ***********************************************
   // Tests
   // ***********************************************
   initial begin
      spm_chstat_t [3:0] t;
      logic [3:0][2:0] tl;
      int n;
      repeat (5) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      chk("fsc_idle", 32'(frame_sync_output), 32'h1);
      for (int a = 0; a < 32; a += 4) begin
         rd(8'(a));
         chk("reset_value", rv, 32'h0);
      end
      for (int c = 0; c < 4; c++) begin
         for (int k = 0; k < 8; k++) begin
            wr(8'(4 * c), 32'h20 | 32'(k));
            for (int p = 0; p < 2; p++) begin
               t = '0;
               tl = '1;
               t[c] = p ? ~sel_bit[k] : sel_bit[k];
               tl[c] = (k == 1) ? 3'(3 + p) : 3'h7;
               line_status <= t;
               receive_level <= tl;
               repeat (3) @(posedge aclk);
               n = (k < 6 && p == 0) ? 1 << c : 0;
               chk("status_pin", 32'(multifunction_status_pin), n);
            end
         end
      end
      line_status <= '0;
      wr(OFS_ISTAT, 32'hFFFFF);
      wr(OFS_IMASK, 32'h1);
      t = '0;
      t[0].signal_lost_indication = 1'b1;
      line_status <= t;
      repeat (3) @(posedge aclk);
      chk("irq_set", 32'(irq), 32'h1);
      rd(OFS_LSTAT);
      chk("lstat", rv, 32'h1);
      wr(OFS_IMASK, 32'h0);
      repeat (2) @(posedge aclk);
      chk("irq_masked", 32'(irq), 32'h0);
      wr(OFS_IMASK, 32'h1);
      repeat (2) @(posedge aclk);
      chk("irq_unmasked", 32'(irq), 32'h1);
      line_status <= '0;
      wr(OFS_ISTAT, 32'h1);
      repeat (2) @(posedge aclk);
      chk("irq_cleared", 32'(irq), 32'h0);
      rd(8'h20);
      chk("rd_unmapped", {resp, rv[29:0]}, {RESP_SLVERR, 30'h0});
      wr(8'h24, 32'h1);
      chk("wr_unmapped", 32'(resp), 32'(RESP_SLVERR));
      t = '0;
      t[2].transmit_overcurrent_indication = 1'b1;
      line_status <= t;
      repeat (3) @(posedge aclk);
      chk("ovc_float", 32'({transmit_line_ring_oe, transmit_line_tip_oe}), 32'hBB);
      line_status <= '0;
      repeat (3) @(posedge aclk);
      chk("ovc_release", 32'({transmit_line_ring_oe, transmit_line_tip_oe}), 32'hFF);
      tri_req <= 4'h2;
      repeat (8) @(posedge aclk);
      chk("tristate", 32'({transmit_line_ring_oe, transmit_line_tip_oe}), 32'hDD);
      wr(8'h04, 32'h127);
      repeat (8) @(posedge aclk);
      chk("dual_rail", 32'({transmit_line_ring_oe, transmit_line_tip_oe,
         transmit_line_tip}), 32'hFF2);
      tri_req <= 4'h0;
      wr(8'h0C, 32'hE7);
      repeat (3) @(posedge aclk);
      chk("cmi", 32'({receive_cmi_enable, transmit_line_ring_oe, transmit_line_tip_oe,
         transmit_line_ring[3], transmit_line_tip}), 32'h11EF0);
      for (int i = 0; i < 4; i++) begin
         dco_active <= 1'b0;
         wr(OFS_GCFG, 32'(fx[i][0]));
         dco_active <= fx[i][1][0];
         repeat (1300) @(posedge aclk);
         n = 0;
         repeat (1250) begin
            @(posedge aclk);
            if (!frame_sync_output) n++;
         end
         chk("fsc_low", n, fx[i][2]);
      end
      for (int i = 0; i < 2; i++) begin
         wr(OFS_GCFG, 32'(1 - i));
         sync_req <= 1'b1;
         @(posedge aclk);
         sync_req <= 1'b0;
         n = 0;
         repeat (30) begin
            @(posedge aclk);
            if (dco_reference_pulse) n++;
         end
         chk("dco_ref", n, 1 - i);
      end
      complete_run();
   end
endmodule
bind spm_top spm_chk u_chk (.aclk, .aresetn, .s_axi_araddr, .s_axi_arvalid,
   .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
   .line_status, .receive_level, .dco_active, .multifunction_status_pin,
   .frame_sync_output, .dco_reference_pulse, .transmit_line_ring_oe,
   .transmit_line_tip_oe);
`default_nettype wire
